// ==== rtl/timer2_pkg.sv ====
// package: register map, field positions and constants of the up/down timer
package timer2_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [3:0] ADDR_CTRL     = 4'h0;
    localparam logic [3:0] ADDR_MODE     = 4'h1;
    localparam logic [3:0] ADDR_CNT_LO   = 4'h2;
    localparam logic [3:0] ADDR_CNT_HI   = 4'h3;
    localparam logic [3:0] ADDR_RLD_LO   = 4'h4;
    localparam logic [3:0] ADDR_RLD_HI   = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;

    // ****************************************
    // control and mode register fields
    // ****************************************
    localparam int CTRL_OVF   = 7;
    localparam int CTRL_EXT   = 6;
    localparam int CTRL_RCLK  = 5;
    localparam int CTRL_TRANSMIT_CLOCK_SOURCE_BIT  = 4;
    localparam int CTRL_EXEN  = 3;
    localparam int CTRL_RUN   = 2;
    localparam int CTRL_CSEL  = 1;
    localparam int CTRL_CPRL  = 0;
    localparam int MODE_UDEN  = 0;

    // interrupt status bits
    localparam int IRQ_OVF    = 0;
    localparam int IRQ_UNF    = 1;
    localparam int IRQ_W      = 2;

    localparam logic [7:0]  BYTE_RST  = 8'h00;
    localparam logic [15:0] CNT_ALL1  = 16'hffff;
    localparam logic [15:0] CNT_ONE   = 16'h0001;

    // ****************************************
    // prescaler: oscillator divided by twelve
    // ****************************************
    localparam int         PRESCALE      = 12;
    localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE - 1);
    localparam logic [3:0] PRESCALE_ZERO = 4'h0;

    typedef enum logic [1:0] {
        MODE_CAPTURE = 2'b00,
        MODE_RELOAD  = 2'b01,
        MODE_BAUD    = 2'b11
    } op_mode_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

endpackage

// ==== rtl/timer2_updown.sv ====
// 16-bit up/down auto-reload timer/counter with register port
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
module timer2_updown (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire timer2_pkg::reg_req_s req,
    output logic [7:0]             rdata,
    input  wire logic              external_count_pin,
    input  wire logic              direction_pin,
    output logic                   irq,
    output logic [16:0]            count_ext
);

    // ****************************************
    // registers
    // ****************************************
    logic [7:0]  ctrl_r;
    logic        updown_en_r;
    logic [7:0]  count_low_byte;
    logic [7:0]  count_high_byte;
    logic [7:0]  reload_low_byte;
    logic [7:0]  reload_high_byte;
    logic [timer2_pkg::IRQ_W-1:0] stat_r;
    logic [timer2_pkg::IRQ_W-1:0] mask_r;
    logic [7:0]  rdata_r;
    logic [3:0]  pre_r;
    logic [2:0]  pin_sync_r;
    logic [2:0]  dir_sync_r;
    logic        pin_lvl_r;
    logic        dir_lvl_r;

    logic [15:0] cnt;
    logic [15:0] rld;
    logic        tick;
    logic        pin_fall;
    logic        run;
    logic        serial;
    logic        updown;
    logic        ovf;
    logic        unf;
    logic        wr_ctrl;
    timer2_pkg::op_mode_e mode;

    function automatic logic hit(input timer2_pkg::reg_req_s r,
                                 input logic [3:0] a);
        return r.wr && (r.addr == a);
    endfunction

    assign cnt = {count_high_byte, count_low_byte};
    assign rld = {reload_high_byte, reload_low_byte};
    assign run = ctrl_r[timer2_pkg::CTRL_RUN];
    assign serial = ctrl_r[timer2_pkg::CTRL_RCLK] |
                    ctrl_r[timer2_pkg::CTRL_TRANSMIT_CLOCK_SOURCE_BIT];
    assign wr_ctrl = hit(req, timer2_pkg::ADDR_CTRL);

    always_comb begin
        if (serial) begin
            mode = timer2_pkg::MODE_BAUD;
        end else if (ctrl_r[timer2_pkg::CTRL_CPRL]) begin
            mode = timer2_pkg::MODE_CAPTURE;
        end else begin
            mode = timer2_pkg::MODE_RELOAD;
        end
    end

    // updown enable qualified by reload mode
    assign updown = updown_en_r && (mode == timer2_pkg::MODE_RELOAD);

    // ****************************************
    // pin synchronisers
    // ****************************************
    // a change counts only once second and third stages agree
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_sync_r <= 3'h7;
            dir_sync_r <= 3'h7;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], external_count_pin};
            dir_sync_r <= {dir_sync_r[1:0], direction_pin};
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_lvl_r <= 1'h1;
            dir_lvl_r <= 1'h1;
        end else begin
            if (pin_sync_r[1] == pin_sync_r[2]) begin
                pin_lvl_r <= pin_sync_r[2];
            end
            if (dir_sync_r[1] == dir_sync_r[2]) begin
                dir_lvl_r <= dir_sync_r[2];
            end
        end
    end

    // falling edge of filtered pin level
    assign pin_fall = pin_lvl_r && (pin_sync_r[1] == pin_sync_r[2]) &&
                      !pin_sync_r[2];

    // ****************************************
    // prescaler
    // ****************************************
    // free-running so the timer rate is independent of run toggling
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_r <= timer2_pkg::PRESCALE_ZERO;
        end else if (pre_r == timer2_pkg::PRESCALE_LAST) begin
            pre_r <= timer2_pkg::PRESCALE_ZERO;
        end else begin
            pre_r <= pre_r + 4'h1;
        end
    end

    // count source select; gated by run
    assign tick = run && (ctrl_r[timer2_pkg::CTRL_CSEL] ? pin_fall :
                  (pre_r == timer2_pkg::PRESCALE_LAST));

    // overflow in up direction or plain mode
    assign ovf = tick && (!updown || dir_lvl_r) && (cnt == timer2_pkg::CNT_ALL1);
    // underflow when count equals reload value
    assign unf = tick && updown && !dir_lvl_r && (cnt == rld);

    // ****************************************
    // counter
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_low_byte  <= timer2_pkg::BYTE_RST;
            count_high_byte <= timer2_pkg::BYTE_RST;
        end else if (ovf && mode != timer2_pkg::MODE_CAPTURE) begin
            {count_high_byte, count_low_byte} <= rld;
        end else if (unf) begin
            {count_high_byte, count_low_byte} <= timer2_pkg::CNT_ALL1;
        end else if (tick) begin
            // cascaded 16-bit step; up unless down
            if (updown && !dir_lvl_r) begin
                {count_high_byte, count_low_byte} <= cnt - timer2_pkg::CNT_ONE;
            end else begin
                {count_high_byte, count_low_byte} <= cnt + timer2_pkg::CNT_ONE;
            end
        end else if (hit(req, timer2_pkg::ADDR_CNT_LO)) begin
            count_low_byte <= req.wdata;
        end else if (hit(req, timer2_pkg::ADDR_CNT_HI)) begin
            count_high_byte <= req.wdata;
        end
    end

    // ****************************************
    // control, mode and reload registers
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= timer2_pkg::BYTE_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= req.wdata;
            end
            // set wins over software write, only without serial
            if ((ovf || unf) && !serial) begin
                ctrl_r[timer2_pkg::CTRL_OVF] <= 1'h1;
            end
            // toggle on each wrap in updown mode
            if (updown && (ovf || unf)) begin
                ctrl_r[timer2_pkg::CTRL_EXT] <= ~ctrl_r[timer2_pkg::CTRL_EXT];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            updown_en_r      <= 1'h0;
            reload_low_byte  <= timer2_pkg::BYTE_RST;
            reload_high_byte <= timer2_pkg::BYTE_RST;
        end else begin
            if (hit(req, timer2_pkg::ADDR_MODE)) begin
                updown_en_r <= req.wdata[timer2_pkg::MODE_UDEN];
            end
            if (hit(req, timer2_pkg::ADDR_RLD_LO)) begin
                reload_low_byte <= req.wdata;
            end
            if (hit(req, timer2_pkg::ADDR_RLD_HI)) begin
                reload_high_byte <= req.wdata;
            end
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    // external flag toggling deliberately feeds no status bit
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_r <= '0;
            mask_r <= '0;
        end else begin
            if (hit(req, timer2_pkg::ADDR_IRQ_MASK)) begin
                mask_r <= req.wdata[timer2_pkg::IRQ_W-1:0];
            end
            stat_r <= (stat_r & ~(hit(req, timer2_pkg::ADDR_IRQ_STAT) ?
                       req.wdata[timer2_pkg::IRQ_W-1:0] : '0)) |
                      {unf && !serial, ovf && !serial};
        end
    end

    assign irq = |(stat_r & mask_r);

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= timer2_pkg::BYTE_RST;
        end else if (req.rd) begin
            unique case (req.addr)
                timer2_pkg::ADDR_CTRL:     rdata_r <= ctrl_r;
                timer2_pkg::ADDR_MODE:     rdata_r <= {7'h00, updown_en_r};
                timer2_pkg::ADDR_CNT_LO:   rdata_r <= count_low_byte;
                timer2_pkg::ADDR_CNT_HI:   rdata_r <= count_high_byte;
                timer2_pkg::ADDR_RLD_LO:   rdata_r <= reload_low_byte;
                timer2_pkg::ADDR_RLD_HI:   rdata_r <= reload_high_byte;
                timer2_pkg::ADDR_IRQ_STAT: rdata_r <= {6'h00, stat_r};
                timer2_pkg::ADDR_IRQ_MASK: rdata_r <= {6'h00, mask_r};
                default:                   rdata_r <= timer2_pkg::BYTE_RST;
            endcase
        end else begin
            rdata_r <= timer2_pkg::BYTE_RST;
        end
    end

    assign rdata = rdata_r;
    assign count_ext = {ctrl_r[timer2_pkg::CTRL_EXT], cnt};

    // ****************************************
    // assertions
    // ****************************************
    property p_reload_up;
        @(posedge core_clk) disable iff (!rst_b)
        (ovf && mode != timer2_pkg::MODE_CAPTURE) |=> cnt == $past(rld);
    endproperty
    a_reload_up: assert property (p_reload_up)
        else $error("overflow did not reload");

    property p_unf_ones;
        @(posedge core_clk) disable iff (!rst_b)
        unf |=> cnt == timer2_pkg::CNT_ALL1;
    endproperty
    a_unf_ones: assert property (p_unf_ones)
        else $error("underflow did not load ones");

    property p_hold;
        @(posedge core_clk) disable iff (!rst_b)
        (!run && !req.wr) |=> $stable(cnt);
    endproperty
    a_hold: assert property (p_hold)
        else $error("count moved while stopped");

    property p_ovf_flag;
        @(posedge core_clk) disable iff (!rst_b)
        ((ovf || unf) && !serial) |=> ctrl_r[timer2_pkg::CTRL_OVF];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag)
        else $error("overflow flag not set");

    property p_ext_tog;
        @(posedge core_clk) disable iff (!rst_b)
        (updown && (ovf || unf)) |=> ctrl_r[timer2_pkg::CTRL_EXT] !=
        $past(ctrl_r[timer2_pkg::CTRL_EXT]);
    endproperty
    a_ext_tog: assert property (p_ext_tog)
        else $error("external flag did not toggle");

    // plain step leaves out the capture wrap, since ovf is excluded
    property p_step_up;
        @(posedge core_clk) disable iff (!rst_b)
        (tick && !ovf && !(updown && !dir_lvl_r)) |=>
        cnt == $past(cnt) + timer2_pkg::CNT_ONE;
    endproperty
    a_step_up: assert property (p_step_up)
        else $error("count did not step up");

    property p_step_down;
        @(posedge core_clk) disable iff (!rst_b)
        (tick && updown && !dir_lvl_r && !unf) |=>
        cnt == $past(cnt) - timer2_pkg::CNT_ONE;
    endproperty
    a_step_down: assert property (p_step_down)
        else $error("count did not step down");

    c_unf: cover property (@(posedge core_clk) unf);
    c_ovf: cover property (@(posedge core_clk) ovf && updown);
    c_irq: cover property (@(posedge core_clk) irq);
    c_wrap: cover property (@(posedge core_clk)
        ovf && mode == timer2_pkg::MODE_CAPTURE);

endmodule

// ==== test/timer2_pins_model.sv ====
// model of the external count pin and direction pin
`timescale 1ns/100ps
module timer2_pins_model (
    input  wire logic core_clk,
    output logic      external_count_pin,
    output logic      direction_pin
);
    // ****************************************
    // pin drivers
    // ****************************************
    initial begin
        external_count_pin = 1'b1;
        direction_pin      = 1'b1;
    end

    // falling edges
    // each low and high phase outlasts the synchroniser delay
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge core_clk) external_count_pin <= 1'b0;
            repeat (5) @(posedge core_clk);
            external_count_pin <= 1'b1;
            repeat (5) @(posedge core_clk);
        end
        repeat (6) @(posedge core_clk);
    endtask

    task automatic set_dir(input logic up);
        @(posedge core_clk) direction_pin <= up;
        repeat (5) @(posedge core_clk);
    endtask
endmodule

// ==== test/test_timer2_updown.sv ====
// self-checking bench for the up/down auto-reload timer
`timescale 1ns/100ps
module test_timer2_updown;
    logic                 core_clk;
    logic                 rst_b;
    timer2_pkg::reg_req_s req;
    logic [7:0]           rdata;
    logic                 ext_pin;
    logic                 dir_pin;
    logic                 irq;
    logic [16:0]          count_ext;
    int                   n_mismatch;
    int                   cmp_count;
    logic [7:0]           rv;

    timer2_updown i_dut (
        .core_clk           (core_clk),
        .rst_b              (rst_b),
        .req                (req),
        .rdata              (rdata),
        .external_count_pin (ext_pin),
        .direction_pin      (dir_pin),
        .irq                (irq),
        .count_ext          (count_ext)
    );

    timer2_pins_model i_pins (
        .core_clk           (core_clk),
        .external_count_pin (ext_pin),
        .direction_pin      (dir_pin)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic setcnt(input logic [15:0] v);
        wr(timer2_pkg::ADDR_CNT_LO, v[7:0]);
        wr(timer2_pkg::ADDR_CNT_HI, v[15:8]);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        n_mismatch = 0;
        cmp_count  = 0;
        rst_b      = 1'b0;
        req        = '0;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(timer2_pkg::ADDR_CTRL, rv); chk(rv, 8'h00);
        rd(timer2_pkg::ADDR_MODE, rv); chk(rv, 8'h00);
        rd(4'h9, rv); chk(rv, 8'h00);
        chk(count_ext, 17'h00000);
        $display("test reset done");

        wr(timer2_pkg::ADDR_RLD_LO, 8'hff);
        wr(timer2_pkg::ADDR_RLD_HI, 8'h12);
        setcnt(16'hfffe);
        wr(timer2_pkg::ADDR_MODE, 8'h01);
        wr(timer2_pkg::ADDR_CTRL, 8'h06);
        i_pins.pulse(1);
        chk(count_ext, 17'h0ffff);
        i_pins.pulse(1);
        chk(count_ext, 17'h112ff);
        rd(timer2_pkg::ADDR_CTRL, rv); chk(rv, 8'hc6);
        rd(timer2_pkg::ADDR_IRQ_STAT, rv); chk(rv, 8'h01);
        chk(irq, 1'b0);
        wr(timer2_pkg::ADDR_IRQ_MASK, 8'h03);
        @(posedge core_clk);
        #1 chk(irq, 1'b1);
        wr(timer2_pkg::ADDR_IRQ_STAT, 8'h01);
        @(posedge core_clk);
        #1 chk(irq, 1'b0);
        wr(timer2_pkg::ADDR_CTRL, 8'h06);
        rd(timer2_pkg::ADDR_CTRL, rv); chk(rv, 8'h06);
        $display("test overflow done");

        i_pins.set_dir(1'b0);
        setcnt(16'h1300);
        i_pins.pulse(1);
        chk(count_ext, 17'h012ff);
        i_pins.pulse(1);
        chk(count_ext, 17'h1ffff);
        rd(timer2_pkg::ADDR_CTRL, rv); chk(rv, 8'hc6);
        rd(timer2_pkg::ADDR_IRQ_STAT, rv); chk(rv, 8'h02);
        wr(timer2_pkg::ADDR_IRQ_STAT, 8'h02);
        wr(timer2_pkg::ADDR_CTRL, 8'h06);
        i_pins.set_dir(1'b1);
        i_pins.pulse(1);
        chk(count_ext, 17'h112ff);
        $display("test underflow done");

        wr(timer2_pkg::ADDR_CTRL, 8'h02);
        i_pins.pulse(2);
        chk(count_ext, 17'h012ff);
        wr(timer2_pkg::ADDR_MODE, 8'h00);
        i_pins.set_dir(1'b0);
        setcnt(16'hffff);
        wr(timer2_pkg::ADDR_CTRL, 8'h16);
        i_pins.pulse(1);
        chk(count_ext, 17'h012ff);
        rd(timer2_pkg::ADDR_CTRL, rv); chk(rv, 8'h16);
        $display("test plain reload done");

        wr(timer2_pkg::ADDR_CTRL, 8'h00);
        setcnt(16'h0000);
        // run stays set for exactly sixty core clocks
        wr(timer2_pkg::ADDR_CTRL, 8'h04);
        repeat (58) @(posedge core_clk);
        wr(timer2_pkg::ADDR_CTRL, 8'h00);
        repeat (4) @(posedge core_clk);
        chk(count_ext, 17'h00005);
        $display("test prescaler done");

        // capture mode wraps to zero with no reload and no up/down
        wr(timer2_pkg::ADDR_IRQ_STAT, 8'h03);
        wr(timer2_pkg::ADDR_MODE, 8'h01);
        setcnt(16'hffff);
        wr(timer2_pkg::ADDR_CTRL, 8'h07);
        i_pins.pulse(1);
        chk(count_ext, 17'h00000);
        rd(timer2_pkg::ADDR_CTRL, rv); chk(rv, 8'h87);
        rd(timer2_pkg::ADDR_IRQ_STAT, rv); chk(rv, 8'h01);
        chk(irq, 1'b1);
        // receive clock forces reload and suppresses the flag
        wr(timer2_pkg::ADDR_CTRL, 8'h00);
        wr(timer2_pkg::ADDR_IRQ_STAT, 8'h03);
        setcnt(16'hffff);
        wr(timer2_pkg::ADDR_CTRL, 8'h26);
        i_pins.pulse(1);
        chk(count_ext, 17'h012ff);
        rd(timer2_pkg::ADDR_IRQ_STAT, rv); chk(rv, 8'h00);
        rd(timer2_pkg::ADDR_CTRL, rv); chk(rv, 8'h26);
        chk(irq, 1'b0);
        $display("test capture and serial done");
        summarize();
    end

    // the tests take about three hundred and forty cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        summarize();
    end
endmodule
